// ==== shared/drive_word_pkg.sv ====
// Purpose: Shared types and constants for the drive command/condition word logic
// Assumes: 16-bit words, bit 0 is the least significant bit
// Notes:   Speed values are signed, 16384 stands for 100 %
package drive_word_pkg;

  localparam int WORD_W = 16;

  // Command word bit positions
  localparam int CB_PRESET_LSB = 0;
  localparam int CB_DC_BRAKE   = 2;
  localparam int CB_COAST      = 3;
  localparam int CB_QUICK_STOP = 4;
  localparam int CB_HOLD       = 5;
  localparam int CB_RAMP_STOP  = 6;
  localparam int CB_RESET      = 7;
  localparam int CB_JOG        = 8;
  localparam int CB_RAMP_SEL   = 9;
  localparam int CB_VALID      = 10;
  localparam int CB_RELAY1     = 11;
  localparam int CB_RELAY2     = 12;
  localparam int CB_SETUP_LSB  = 13;
  localparam int CB_REVERSE    = 15;

  // Condition word bit positions
  localparam int SB_CTRL_READY = 0;
  localparam int SB_DRV_READY  = 1;
  localparam int SB_ENABLE     = 2;
  localparam int SB_TRIP       = 3;
  localparam int SB_ERROR      = 4;
  localparam int SB_UNUSED     = 5;
  localparam int SB_TRIP_LOCK  = 6;
  localparam int SB_WARNING    = 7;
  localparam int SB_AT_REF     = 8;
  localparam int SB_BUS_CTRL   = 9;
  localparam int SB_FREQ_OK    = 10;
  localparam int SB_RUNNING    = 11;
  localparam int SB_AUTO_STOP  = 12;
  localparam int SB_VOLTAGE    = 13;
  localparam int SB_TORQUE     = 14;
  localparam int SB_TIMER      = 15;

  // Reset values: all-zero command word means coast and stop; coast keeps the DC brake off
  localparam logic [15:0] CMD_WORD_RST  = 16'h0000;
  localparam logic [15:0] COND_WORD_RST = 16'h0000;
  localparam logic [15:0] SPEED_RST     = 16'h0000;

  // Relative speed scaling
  localparam logic signed [15:0] SPEED_FULL_SCALE = 16'sh4000;
  localparam logic signed [15:0] SPEED_POS_MAX    = 16'sh7FFF;
  localparam logic signed [15:0] FREEZE_STEP      = 16'sh0040;

  // Source of the reverse command
  typedef enum logic [1:0] {
    REV_DIGITAL = 2'b00,
    REV_BUS     = 2'b01,
    REV_OR      = 2'b10,
    REV_AND     = 2'b11
  } rev_src_t;

  // DC brake sequence, Gray coded along idle-brake-held
  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_ON   = 2'b01,
    BRK_HELD = 2'b11
  } brake_state_t;

  // Commands handed to the motor-control core
  typedef struct packed {
    logic       coast;
    logic       dcBrake;
    logic       quickStop;
    logic       rampStop;
    logic       freeze;
    logic       jog;
    logic       ramp2;
    logic       relay1;
    logic       relay2;
    logic       reverse;
    logic       startPermit;
    logic       tripReset;
    logic [1:0] presetIdx;
    logic [1:0] setupIdx;
  } drive_cmd_t;

  // Conditions reported by the motor-control core
  typedef struct packed {
    logic ctrlReady;
    logic tripped;
    logic errNoTrip;
    logic tripLock;
    logic warning;
    logic startSignal;
    logic overTempStop;
    logic dcVoltOut;
    logic torqueOver;
    logic thermalOver;
    logic localRefSite;
  } drive_cond_t;

endpackage

// ==== logic/pin_sync3.sv ====
// Purpose: Three-stage synchroniser for pin-level inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   Output follows only once stages two and three agree
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // Accept a bit only when the two settled stages match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          pinOut[i] <= stage3_q[i];
        end
      end
    end
  end

endmodule // pin_sync3

// ==== logic/drive_control_status_word_logic.sv ====
// Purpose: Decode the bus command word, build the drive condition word
// Assumes: One clock; word strobe from the frame decoder is one cycle
// Notes:   Core-side inputs are on clk; digital inputs arrive from pins
// How it works
// - Bits 1:0 pick one of four presets
// - Bit 2 low brakes by DC then stops
// - Bit 3 low coasts; high permits start
// - Bit 4 low ramps down on quick ramp
// - Bit 5 low freezes output frequency
// - Frozen: only coast or brake stop
// - Bit 6 low ramp stop; high permits start
// - Trip reset only on rising bit 7
// - Bit 8 high uses jog speed
// - Bit 10 low ignores whole word
// - Bits 11, 12 drive selected relays
// - Bits 14:13 pick set-up if multi
// - Bit 15 reverses per reverse source
// - Status bits 0, 1 show readiness
// - Bits 3, 4, 6 fault severity; 5 zero
// - Bit 7 warning, bit 8 at reference
// - Bit 9 shows bus may control
// - Bits 10-12 limits, running, auto-stop
// - Bits 13-15 voltage, torque, thermal flags
// - Link loss forces condition word zero
// - Speeds are signed, 16384 equals 100%
`timescale 1ns/100ps
module drive_control_status_word_logic
  import drive_word_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               wordStrobe,
  input  wire logic [15:0]        driveCommandWord,
  input  wire logic [15:0]        busSpeedSetpoint,
  input  wire logic [15:0]        jogSpeed,
  input  wire logic [15:0]        dcBrakeCycles,
  input  wire logic               relay1BusSel,
  input  wire logic               relay2BusSel,
  input  wire logic               multiSetup,
  input  wire rev_src_t           reverseSource,
  input  wire logic               pinSpeedUp,
  input  wire logic               pinSlowDown,
  input  wire logic               pinDcBrake,
  input  wire logic               pinCoast,
  input  wire logic               pinResetCoast,
  input  wire logic               pinReverse,
  input  wire logic               pinLocalStop,
  input  wire drive_cond_t        coreCond,
  input  wire logic signed [15:0] outputFreq,
  input  wire logic signed [15:0] motorSpeed,
  input  wire logic signed [15:0] speedLowLimit,
  input  wire logic signed [15:0] speedHighLimit,
  input  wire logic               linkLost,
  input  wire logic               commFault,
  output drive_cmd_t              driveCmd,
  output logic signed [15:0]      freqReference,
  output logic [15:0]             driveConditionWord,
  output logic signed [15:0]      actualFrequencyFeedback
);

  logic [15:0]        cmd_q;
  logic [15:0]        setpoint_q;
  logic               resetBit_q;
  logic               frozen_q;
  logic signed [15:0] hold_q;
  logic [1:0]         setup_q;
  logic               speedUpPrev_q;
  logic               slowDownPrev_q;
  logic [15:0]        brakeCnt_q;
  brake_state_t       brake_q;
  brake_state_t       brake_d;
  logic [6:0]         pins;
  logic               accept;
  logic               speedUp;
  logic               slowDown;
  logic               dinDcBrake;
  logic               dinCoast;
  logic               dinResetCoast;
  logic               dinReverse;
  logic               localStop;
  logic               coastCmd;
  logic               brakeCmd;
  logic               reverseCmd;
  logic [15:0]        cond_d;

  // Clamp a signed step so the held value never wraps
  function automatic logic signed [15:0] stepSat(
    input logic signed [15:0] val,
    input logic               up
  );
    logic signed [16:0] sum;
    sum = up ? 17'(val) + 17'(FREEZE_STEP) : 17'(val) - 17'(FREEZE_STEP);
    if (sum > 17'(SPEED_POS_MAX)) begin
      stepSat = SPEED_POS_MAX;
    end else if (sum < -17'(SPEED_POS_MAX)) begin
      stepSat = -SPEED_POS_MAX;
    end else begin
      stepSat = sum[15:0];
    end
  endfunction

  pin_sync3 #(
    .W(7)
  ) u_pins (
    .clk   (clk),
    .rst_n (rst_n),
    .pinIn ({pinLocalStop, pinReverse, pinResetCoast, pinCoast,
             pinDcBrake, pinSlowDown, pinSpeedUp}),
    .pinOut(pins)
  );

  assign speedUp       = pins[0];
  assign slowDown      = pins[1];
  assign dinDcBrake    = pins[2];
  assign dinCoast      = pins[3];
  assign dinResetCoast = pins[4];
  assign dinReverse    = pins[5];
  assign localStop     = pins[6];

  assign accept = wordStrobe && driveCommandWord[CB_VALID];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q      <= CMD_WORD_RST;
      setpoint_q <= SPEED_RST;
    end else if (accept) begin
      cmd_q      <= driveCommandWord;
      setpoint_q <= busSpeedSetpoint;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetBit_q <= 1'b0;
    end else if (accept) begin
      resetBit_q <= driveCommandWord[CB_RESET];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= 2'h0;
    end else if (accept && multiSetup) begin
      setup_q <= driveCommandWord[CB_SETUP_LSB +: 2];
    end
  end

  assign coastCmd = !cmd_q[CB_COAST] || dinCoast || dinResetCoast;
  // DC brake from bit or pin
  assign brakeCmd = !cmd_q[CB_DC_BRAKE] || dinDcBrake;

  // brake for set time then hold stop
  always_comb begin
    brake_d = brake_q;
    case (brake_q)
      BRK_IDLE: begin
        if (brakeCmd && !coastCmd) begin
          brake_d = BRK_ON;
        end
      end
      BRK_ON: begin
        if (!brakeCmd || coastCmd) begin
          brake_d = BRK_IDLE;
        end else if (brakeCnt_q >= dcBrakeCycles) begin
          brake_d = BRK_HELD;
        end
      end
      BRK_HELD: begin
        if (!brakeCmd) begin
          brake_d = BRK_IDLE;
        end
      end
      default: brake_d = BRK_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brake_q    <= BRK_IDLE;
      brakeCnt_q <= 16'h0000;
    end else begin
      brake_q    <= brake_d;
      brakeCnt_q <= (brake_d == BRK_ON) ? brakeCnt_q + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frozen_q       <= 1'b0;
      hold_q         <= SPEED_RST;
      speedUpPrev_q  <= 1'b0;
      slowDownPrev_q <= 1'b0;
    end else begin
      speedUpPrev_q  <= speedUp;
      slowDownPrev_q <= slowDown;
      frozen_q       <= !cmd_q[CB_HOLD];
      if (cmd_q[CB_HOLD]) begin
        hold_q <= outputFreq;
      end else if (speedUp && !speedUpPrev_q) begin
        hold_q <= stepSat(hold_q, 1'b1);
      end else if (slowDown && !slowDownPrev_q) begin
        hold_q <= stepSat(hold_q, 1'b0);
      end
    end
  end

  always_comb begin
    case (reverseSource)
      REV_BUS: reverseCmd = cmd_q[CB_REVERSE];
      REV_OR:  reverseCmd = cmd_q[CB_REVERSE] || dinReverse;
      REV_AND: reverseCmd = cmd_q[CB_REVERSE] && dinReverse;
      default: reverseCmd = dinReverse;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      driveCmd      <= '0;
      freqReference <= SPEED_RST;
    end else begin
      driveCmd.coast       <= coastCmd;
      driveCmd.dcBrake     <= brake_d == BRK_ON;
      driveCmd.quickStop   <= !cmd_q[CB_QUICK_STOP] && cmd_q[CB_HOLD];
      driveCmd.rampStop    <= !cmd_q[CB_RAMP_STOP] && cmd_q[CB_HOLD];
      driveCmd.startPermit <= cmd_q[CB_RAMP_STOP] && !coastCmd
                              && brake_d == BRK_IDLE;
      driveCmd.freeze      <= frozen_q;
      driveCmd.jog         <= cmd_q[CB_JOG];
      driveCmd.ramp2       <= cmd_q[CB_RAMP_SEL];
      driveCmd.relay1      <= relay1BusSel && cmd_q[CB_RELAY1];
      driveCmd.relay2      <= relay2BusSel && cmd_q[CB_RELAY2];
      driveCmd.reverse     <= reverseCmd;
      // one pulse on rising reset bit
      driveCmd.tripReset   <= accept && driveCommandWord[CB_RESET] && !resetBit_q;
      driveCmd.presetIdx   <= cmd_q[CB_PRESET_LSB +: 2];
      driveCmd.setupIdx    <= setup_q;
      if (cmd_q[CB_JOG]) begin
        freqReference <= jogSpeed;
      end else if (frozen_q) begin
        freqReference <= hold_q;
      end else begin
        freqReference <= setpoint_q;
      end
    end
  end

  always_comb begin
    cond_d                = 16'h0000;
    cond_d[SB_CTRL_READY] = coreCond.ctrlReady && !coreCond.tripped;
    cond_d[SB_DRV_READY]  = coreCond.ctrlReady && !coreCond.tripped && coastCmd;
    cond_d[SB_ENABLE]     = !coastCmd;
    cond_d[SB_TRIP]       = coreCond.tripped;
    cond_d[SB_ERROR]      = coreCond.errNoTrip;
    cond_d[SB_UNUSED]     = 1'b0;
    cond_d[SB_TRIP_LOCK]  = coreCond.tripLock;
    cond_d[SB_WARNING]    = coreCond.warning;
    cond_d[SB_AT_REF]     = motorSpeed == freqReference;
    cond_d[SB_BUS_CTRL]   = !localStop && !coreCond.localRefSite;
    cond_d[SB_FREQ_OK]    = outputFreq > speedLowLimit && outputFreq < speedHighLimit;
    cond_d[SB_RUNNING]    = coreCond.startSignal || outputFreq != 16'sh0000;
    cond_d[SB_AUTO_STOP]  = coreCond.overTempStop && !coreCond.tripped;
    cond_d[SB_VOLTAGE]    = coreCond.dcVoltOut;
    cond_d[SB_TORQUE]     = coreCond.torqueOver;
    cond_d[SB_TIMER]      = coreCond.thermalOver;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      driveConditionWord      <= COND_WORD_RST;
      actualFrequencyFeedback <= SPEED_RST;
    end else begin
      driveConditionWord      <= (linkLost || commFault) ? COND_WORD_RST : cond_d;
      actualFrequencyFeedback <= outputFreq;
    end
  end

  // Checks
  sequence s_validWord;
    wordStrobe && driveCommandWord[CB_VALID];
  endsequence

  sequence s_resetRise;
    s_validWord ##0 driveCommandWord[CB_RESET] && !resetBit_q;
  endsequence

  chk_invalid_ignored: assert property (
    @(posedge clk) disable iff (!rst_n)
    wordStrobe && !driveCommandWord[CB_VALID] |=> $stable(cmd_q))
    else $error("Invalid command word was applied");

  chk_word_atomic: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_validWord |=> cmd_q == $past(driveCommandWord)
                    && setpoint_q == $past(busSpeedSetpoint))
    else $error("Command word not applied whole");

  chk_reset_edge: assert property (
    @(posedge clk) disable iff (!rst_n)
    driveCmd.tripReset |-> $past(wordStrobe) && $past(driveCommandWord[CB_RESET])
                           && !$past(resetBit_q))
    else $error("Trip reset without a rising edge");

  chk_reset_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_resetRise |=> driveCmd.tripReset ##1 !driveCmd.tripReset || $past(accept))
    else $error("Trip reset pulse missing or long");

  chk_preset_index: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_validWord ##1 !accept |=> driveCmd.presetIdx == $past(cmd_q[1:0]))
    else $error("Preset index does not follow word");

  chk_frozen_noramp: assert property (
    @(posedge clk) disable iff (!rst_n)
    !cmd_q[CB_HOLD] |=> !driveCmd.quickStop && !driveCmd.rampStop)
    else $error("Ramp stop while frequency frozen");

  chk_coast_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    !cmd_q[CB_COAST] |=> driveCmd.coast && !driveCmd.startPermit)
    else $error("Coast bit did not release motor");

  chk_jog_ref: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_q[CB_JOG] |=> freqReference == $past(jogSpeed))
    else $error("Jog speed not used");

  chk_link_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    linkLost || commFault |=> driveConditionWord == 16'h0000)
    else $error("Condition word not cleared on link loss");

  chk_setup_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    !multiSetup |=> $stable(setup_q))
    else $error("Set-up changed outside multi mode");

  chk_bit5_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    !driveConditionWord[SB_UNUSED])
    else $error("Unused condition bit set");

endmodule // drive_control_status_word_logic

// ==== sim/bus_master_model.sv ====
// Purpose: Bus master stand-in that hands command words and setpoints to the drive
// Assumes: One word per strobe; strobe high for exactly one cycle
// Notes:   Lines are scrambled between words so stale data is never trusted
`timescale 1ns/100ps
module bus_master_model (
  input  wire logic   clk,
  output logic        wordStrobe,
  output logic [15:0] driveCommandWord,
  output logic [15:0] busSpeedSetpoint
);
  initial begin
    wordStrobe       = 1'b0;
    driveCommandWord = 16'h0000;
    busSpeedSetpoint = 16'h0000;
  end

  task automatic send(input logic [15:0] word, input logic [15:0] speed, input int gap);
    repeat (gap) @(posedge clk);
    wordStrobe       <= 1'b1;
    driveCommandWord <= word;
    busSpeedSetpoint <= speed;
    @(posedge clk);
    wordStrobe       <= 1'b0;
    driveCommandWord <= ~word;
    busSpeedSetpoint <= ~speed;
  endtask
endmodule // bus_master_model

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the command word decoder and condition word
// Assumes: 250 MHz clock, pins held steady long enough to pass the synchroniser
// Notes:   Slow-down, brake and reset-coast pins stay low; speed-up and coast pins are pulsed
`timescale 1ns/100ps
module testbench;
  import drive_word_pkg::*;
  logic               clk            = 1'b0;
  logic               rst_n          = 1'b0;
  logic               wordStrobe;
  logic [15:0]        driveCommandWord;
  logic [15:0]        busSpeedSetpoint;
  logic [15:0]        jogSpeed       = 16'h0000;
  logic [15:0]        dcBrakeCycles  = 16'h0005;
  logic               relay1BusSel   = 1'b0;
  logic               relay2BusSel   = 1'b0;
  logic               multiSetup     = 1'b0;
  rev_src_t           reverseSource  = REV_DIGITAL;
  logic               pinReverse     = 1'b0;
  logic               pinLocalStop   = 1'b0;
  logic               pinSpeedUp     = 1'b0;
  logic               pinCoast       = 1'b0;
  drive_cond_t        coreCond       = '0;
  logic signed [15:0] outputFreq     = 16'sh0000;
  logic signed [15:0] motorSpeed     = 16'sh0000;
  logic signed [15:0] speedLowLimit  = 16'sh0000;
  logic signed [15:0] speedHighLimit = 16'sh0000;
  logic               linkLost       = 1'b0;
  logic               commFault      = 1'b0;
  drive_cmd_t         driveCmd;
  logic signed [15:0] freqReference;
  logic [15:0]        driveConditionWord;
  logic signed [15:0] actualFrequencyFeedback;
  logic [15:0]        w;
  logic [15:0]        wM             = 16'h0000;
  logic [15:0]        spM            = 16'h0000;
  logic [15:0]        e;
  logic [1:0]         setupM         = 2'b00;
  integer             seed           = 32'h41EF1A69;
  int                 miscompares    = 0;
  int                 samplesChecked = 0;
  int                 n;

  always #2 clk = ~clk;

  bus_master_model u_bus_master_model (
    .clk              (clk),
    .wordStrobe       (wordStrobe),
    .driveCommandWord (driveCommandWord),
    .busSpeedSetpoint (busSpeedSetpoint)
  );

  drive_control_status_word_logic u_drive_control_status_word_logic (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .wordStrobe              (wordStrobe),
    .driveCommandWord        (driveCommandWord),
    .busSpeedSetpoint        (busSpeedSetpoint),
    .jogSpeed                (jogSpeed),
    .dcBrakeCycles           (dcBrakeCycles),
    .relay1BusSel            (relay1BusSel),
    .relay2BusSel            (relay2BusSel),
    .multiSetup              (multiSetup),
    .reverseSource           (reverseSource),
    .pinSpeedUp              (pinSpeedUp),
    .pinSlowDown             (1'b0),
    .pinDcBrake              (1'b0),
    .pinCoast                (pinCoast),
    .pinResetCoast           (1'b0),
    .pinReverse              (pinReverse),
    .pinLocalStop            (pinLocalStop),
    .coreCond                (coreCond),
    .outputFreq              (outputFreq),
    .motorSpeed              (motorSpeed),
    .speedLowLimit           (speedLowLimit),
    .speedHighLimit          (speedHighLimit),
    .linkLost                (linkLost),
    .commFault               (commFault),
    .driveCmd                (driveCmd),
    .freqReference           (freqReference),
    .driveConditionWord      (driveConditionWord),
    .actualFrequencyFeedback (actualFrequencyFeedback)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Sends one word, then checks the pulse at +1 and the decoded levels at +3
  task automatic sendCheck(input logic [15:0] wd, input logic [15:0] sp);
    drive_cmd_t s;
    drive_cmd_t c;
    logic       pulse;
    pulse = wd[10] & wd[7] & ~wM[7];
    if (wd[10]) begin
      wM  = wd;
      spM = sp;
      if (multiSetup) begin
        setupM = wd[14:13];
      end
    end
    u_bus_master_model.send(wd, sp, 1);
    // Pulse stands only in the cycle after the accepting edge
    #1;
    check(16'(driveCmd.tripReset), 16'(pulse), "trip reset pulse");
    repeat (2) @(posedge clk);
    #1;
    c           = '0;
    c.coast     = ~wM[3];
    c.freeze    = ~wM[5];
    c.quickStop = ~wM[4] & wM[5];
    c.rampStop  = ~wM[6] & wM[5];
    c.jog       = wM[8];
    c.ramp2     = wM[9];
    c.relay1    = wM[11] & relay1BusSel;
    c.relay2    = wM[12] & relay2BusSel;
    c.presetIdx = wM[1:0];
    c.setupIdx  = setupM;
    case (reverseSource)
      REV_BUS: c.reverse = wM[15];
      REV_OR:  c.reverse = wM[15] | pinReverse;
      REV_AND: c.reverse = wM[15] & pinReverse;
      default: c.reverse = pinReverse;
    endcase
    s             = driveCmd;
    s.dcBrake     = 1'b0;
    s.startPermit = 1'b0;
    s.tripReset   = 1'b0;
    check(s, c, "command fields");
    if (c.jog || !c.freeze) begin
      check(freqReference, c.jog ? jogSpeed : spM, "reference");
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 48; i++) begin
      @(posedge clk);
      w        = 16'($random(seed));
      w[2]     = 1'b1;
      w[1:0]   = i[1:0];
      w[14:13] = i[3:2];
      if (i[3:0] == 4'h0) begin
        w[10] = 1'b1;
        multiSetup <= i[4];
      end
      reverseSource <= rev_src_t'(i[2:1]);
      pinReverse    <= 1'($random(seed));
      relay1BusSel  <= 1'($random(seed));
      relay2BusSel  <= 1'($random(seed));
      jogSpeed      <= 16'($random(seed));
      repeat (5) @(posedge clk);
      sendCheck(w, 16'($random(seed)));
    end
    $display("command decode test done");
    @(posedge clk);
    dcBrakeCycles <= 16'h0004;
    sendCheck(16'h047B, 16'h4000);
    n = 0;
    while (driveCmd.dcBrake === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
      #1;
    end
    // The first brake cycle passes inside sendCheck
    check(16'(n), dcBrakeCycles - 16'h0001, "brake length");
    check(16'(driveCmd.startPermit), 16'h0000, "stopped after brake");
    sendCheck(16'h0474, 16'h4000);
    check(16'(driveCmd.startPermit), 16'h0000, "coast blocks start");
    sendCheck(16'h047C, 16'h4000);
    check(16'(driveCmd.startPermit), 16'h0001, "start permitted");
    $display("brake and start test done");
    @(posedge clk);
    outputFreq <= 16'sh2000;
    sendCheck(16'h040C, 16'h1000);
    check(freqReference, 16'h2000, "frozen reference");
    @(posedge clk);
    pinSpeedUp <= 1'b1;
    pinCoast   <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check(freqReference, 16'(16'sh2000 + FREEZE_STEP), "trimmed reference");
    check(16'(driveCmd.coast), 16'h0001, "pin coast while frozen");
    @(posedge clk);
    pinSpeedUp <= 1'b0;
    pinCoast   <= 1'b0;
    repeat (6) @(posedge clk);
    sendCheck(16'h047C, 16'h4000);
    $display("freeze test done");
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      coreCond       <= drive_cond_t'(11'($random(seed)));
      pinLocalStop   <= 1'($random(seed));
      outputFreq     <= (i % 3 == 0) ? 16'sh0000 : 16'($random(seed) & 32'h3FFF);
      motorSpeed     <= i[0] ? 16'sh4000 : 16'($random(seed));
      speedLowLimit  <= 16'($random(seed) & 32'h1FFF);
      speedHighLimit <= 16'(32'h2000 + ($random(seed) & 32'h1FFF));
      linkLost       <= (i % 7 == 3);
      commFault      <= (i % 9 == 5);
      repeat (5) @(posedge clk);
      #1;
      e     = 16'h0000;
      e[0]  = coreCond.ctrlReady & ~coreCond.tripped;
      e[1]  = coreCond.ctrlReady & ~coreCond.tripped & ~wM[3];
      e[2]  = wM[3];
      e[3]  = coreCond.tripped;
      e[4]  = coreCond.errNoTrip;
      e[6]  = coreCond.tripLock;
      e[7]  = coreCond.warning;
      e[8]  = (motorSpeed == spM);
      e[9]  = ~pinLocalStop & ~coreCond.localRefSite;
      e[10] = (outputFreq > speedLowLimit) && (outputFreq < speedHighLimit);
      e[11] = coreCond.startSignal | (outputFreq > 0);
      e[12] = coreCond.overTempStop & ~coreCond.tripped;
      e[13] = coreCond.dcVoltOut;
      e[14] = coreCond.torqueOver;
      e[15] = coreCond.thermalOver;
      if (linkLost || commFault) begin
        check(driveConditionWord, 16'h0000, "link lost word");
      end else begin
        check(driveConditionWord, e, "condition word");
      end
      check(actualFrequencyFeedback, outputFreq, "frequency feedback");
    end
    $display("condition word test done");
    test_done;
  end
endmodule // testbench
